// ---- core/ufs_ahb_front.sv ----
`timescale 1ns/1ps
module ufs_ahb_front
   import ufs_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output ufs_bus_req_type req
);

   typedef struct packed {
      logic act;
      logic write;
      logic [7:0] addr;
   } ufs_front_type;

   ufs_front_type s_q;
   ufs_front_type s_d;

   // Capture a NONSEQ or SEQ address phase; the data phase follows next cycle
   always_comb begin
      s_d = s_q;
      s_d.act = 1'b0;
      if (hsel && hready && htrans[1]) begin
         s_d.act = 1'b1;
         s_d.write = hwrite;
         s_d.addr = haddr[7:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Zero wait states, always OKAY: every register answers in one data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign req.wr = s_q.act && s_q.write;
   assign req.rd = s_q.act && !s_q.write;
   assign req.addr = s_q.addr;

endmodule : ufs_ahb_front

// ---- core/ufs_endpoint.sv ----
`timescale 1ns/1ps
module ufs_endpoint
   import ufs_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sof,
   input wire ufs_tx_evt_type tx_evt,
   input wire logic rx_setup_token,
   input wire ufs_rx_evt_type rx_evt,
   output ufs_resp_type tx_resp,
   output ufs_resp_type rx_resp,
   output logic [UFS_TX_CNT_W-1:0] tx_byte_count,
   output logic rx_irq,
   output logic sof_irq
);

   typedef struct packed {
      logic [UFS_CTRL_W-1:0] ctrl;
      logic [UFS_TX_CNT_W-1:0] tx_cnt;
      logic [1:0] tx_valid;
      logic [1:0] tx_pend;
      logic tx_wsel;
      logic tx_rsel;
      logic tx_urf_pend;
      logic tx_err;
      logic tx_ack;
      logic tx_void;
      logic tx_ovf;
      logic tx_urf;
      logic tx_flush;
      logic [1:0] rx_valid;
      logic rx_wsel;
      logic rx_rsel;
      logic rx_err;
      logic rx_ack;
      logic rx_void;
      logic rx_setup;
      logic rx_ovf;
      logic rx_urf;
      logic setup_ow;
      logic end_ow;
      ufs_resp_type tx_resp;
      ufs_resp_type rx_resp;
      logic rx_irq;
      logic sof_irq;
   } ufs_state_type;

   ufs_state_type s_q;
   ufs_state_type s_d;
   ufs_bus_req_type req;
   logic [1:0] tx_avail;
   logic [1:0] tx_left;
   logic rx_fifo_err;
   logic rx_out_ok;

   ufs_ahb_front u_front (
      .clock(clock),
      .arst_n(arst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .req(req)
   );

   // Buffers handed to USB this frame stay counted until the frame ends
   assign tx_avail = s_q.tx_valid & ~s_q.tx_pend;
   assign tx_left = s_q.tx_valid & ~s_q.tx_pend;
   assign rx_fifo_err = s_q.rx_ovf || s_q.rx_urf;
   // OUT data may be taken: enabled, no error, room for a packet
   assign rx_out_ok = !rx_fifo_err && s_q.ctrl[UFS_CTRL_RX_IE] && !s_q.ctrl[UFS_CTRL_RX_STALL]
      && (s_q.ctrl[UFS_CTRL_RX_SPM] ? (s_q.rx_valid == UFS_CNT_EMPTY)
                                   : (s_q.rx_valid != UFS_CNT_TWO));

   // Register read mux; hsize is ignored since only whole words are mapped
   always_comb begin
      hrdata = '0;
      if (req.rd) begin
         unique case (req.addr)
            UFS_REG_CTRL: hrdata[UFS_CTRL_W-1:0] = s_q.ctrl;
            UFS_REG_TX_CNT: hrdata[UFS_TX_CNT_W-1:0] = s_q.tx_cnt;
            UFS_REG_TX_STAT: hrdata[UFS_TXS_FLUSH:0] = {s_q.tx_flush, s_q.tx_urf, s_q.tx_ovf,
               s_q.tx_void, s_q.tx_ack, s_q.tx_err, s_q.tx_valid};
            UFS_REG_RX_STAT: hrdata[UFS_RXS_END_DATA_OVERWRITE_FLAG:0] = {s_q.end_ow, s_q.setup_ow, s_q.rx_urf,
               s_q.rx_ovf, s_q.rx_setup, s_q.rx_void, s_q.rx_ack, s_q.rx_err, s_q.rx_valid};
            default: hrdata = '0;
         endcase
      end
   end

   // Next state: firmware clears first, hardware events after, so a set wins
   always_comb begin
      s_d = s_q;
      s_d.tx_resp = '0;
      s_d.rx_resp = '0;
      s_d.rx_irq = 1'b0;
      s_d.sof_irq = 1'b0;
      if (req.wr) begin
         unique case (req.addr)
            UFS_REG_CTRL: s_d.ctrl = hwdata[UFS_CTRL_W-1:0];
            UFS_REG_TX_CNT: begin
               s_d.tx_cnt = hwdata[UFS_TX_CNT_W-1:0];
               if (s_q.tx_valid == UFS_CNT_TWO) begin
                  s_d.tx_ovf = 1'b1;
               end else begin
                  s_d.tx_valid[s_q.tx_wsel] = 1'b1;
                  s_d.tx_wsel = !s_q.tx_wsel;
               end
            end
            UFS_REG_TX_STAT: begin
               if (hwdata[UFS_TXS_OVF]) s_d.tx_ovf = 1'b0;
               if (hwdata[UFS_TXS_URF]) s_d.tx_urf = 1'b0;
               if (hwdata[UFS_TXS_FLUSH]) s_d.tx_flush = 1'b0;
            end
            UFS_REG_RX_STAT: begin
               if (hwdata[UFS_RXS_SETUP]) s_d.rx_setup = 1'b0;
               if (hwdata[UFS_RXS_OVF]) s_d.rx_ovf = 1'b0;
               if (hwdata[UFS_RXS_URF]) s_d.rx_urf = 1'b0;
               if (hwdata[UFS_RXS_END_DATA_OVERWRITE_FLAG]) s_d.end_ow = 1'b0;
            end
            UFS_REG_RX_CMD: begin
               if (hwdata[UFS_RXC_DONE] && s_q.rx_valid[s_q.rx_rsel]) begin
                  s_d.rx_valid[s_q.rx_rsel] = 1'b0;
                  s_d.rx_rsel = !s_q.rx_rsel;
               end
            end
            default: s_d.ctrl = s_q.ctrl;
         endcase
      end
      // CPU data read of an empty buffer is an underrun, never an interrupt
      if (req.rd && req.addr == UFS_REG_RX_DATA && !s_q.rx_valid[s_q.rx_rsel]) begin
         s_d.rx_urf = 1'b1;
      end

      // Isochronous IN token; only flags and the read pointer move now, the count waits for the frame
      if (tx_evt.in_done && s_q.ctrl[UFS_CTRL_TX_EP_EN]) begin
         s_d.tx_resp.valid = 1'b1;
         if (!s_q.ctrl[UFS_CTRL_TX_OE]) begin
            s_d.tx_resp.code = UFS_HS_NONE;
            s_d.tx_void = 1'b1;
            s_d.tx_err = 1'b0;
            s_d.tx_ack = 1'b0;
         end else if (s_q.tx_ovf || s_q.tx_urf || tx_avail == UFS_CNT_EMPTY) begin
            s_d.tx_resp.code = UFS_HS_NONE;
            s_d.tx_void = 1'b1;
         end else begin
            s_d.tx_pend[s_q.tx_rsel] = 1'b1;
            s_d.tx_rsel = !s_q.tx_rsel;
            s_d.tx_void = 1'b0;
            s_d.tx_err = tx_evt.underrun;
            s_d.tx_ack = !tx_evt.underrun;
            s_d.tx_urf_pend = s_q.tx_urf_pend || tx_evt.underrun;
            s_d.tx_resp.code = tx_evt.underrun ? UFS_HS_BADSTUFF : UFS_HS_DATA;
         end
      end

      // Frame start: retire sent packets, drop a stale one left unread
      if (sof) begin
         s_d.tx_valid = tx_left;
         // An IN on this same edge keeps its own buffer and underrun pending
         s_d.tx_pend = s_d.tx_pend & ~s_q.tx_pend;
         s_d.tx_urf_pend = (s_d.tx_pend != 2'h0) && tx_evt.underrun;
         if (s_q.tx_urf_pend) s_d.tx_urf = 1'b1;
         if (tx_left == UFS_CNT_TWO && s_d.tx_pend == 2'h0) begin
            s_d.tx_valid[s_q.tx_rsel] = 1'b0;
            s_d.tx_rsel = !s_q.tx_rsel;
            s_d.tx_flush = 1'b1;
            s_d.sof_irq = 1'b1;
         end
         // A count write in this same cycle still lands in its buffer
         if (req.wr && req.addr == UFS_REG_TX_CNT && s_q.tx_valid != UFS_CNT_TWO) begin
            s_d.tx_valid[s_q.tx_wsel] = 1'b1;
         end
      end

      // Setup token seen: overwrite flag raised until the handshake
      if (rx_setup_token) s_d.setup_ow = 1'b1;

      // Receive transaction end
      if (rx_evt.valid && s_q.ctrl[UFS_CTRL_RX_EP_EN]) begin
         s_d.rx_resp.valid = 1'b1;
         s_d.rx_resp.code = UFS_HS_NONE;
         if (rx_evt.setup) begin
            // SETUP ignores input enable and stall, and restarts the buffer
            s_d.setup_ow = 1'b0;
            s_d.end_ow = 1'b1;
            s_d.rx_valid = UFS_CNT_EMPTY;
            s_d.rx_wsel = 1'b0;
            s_d.rx_rsel = 1'b0;
            s_d.rx_ovf = 1'b0;
            s_d.rx_urf = 1'b0;
            s_d.rx_void = 1'b0;
            s_d.rx_irq = 1'b1;
            s_d.rx_err = (rx_evt.outcome != UFS_RX_OK);
            s_d.rx_ack = (rx_evt.outcome == UFS_RX_OK);
            s_d.rx_setup = (rx_evt.outcome != UFS_RX_TIMEOUT);
            if (rx_evt.outcome == UFS_RX_OK) begin
               s_d.rx_valid = 2'h1;
               s_d.rx_wsel = 1'b1;
               s_d.rx_resp.code = UFS_HS_ACK;
            end else if (rx_evt.outcome == UFS_RX_OVFL) begin
               s_d.rx_ovf = 1'b1;
            end
         end else if (!rx_out_ok) begin
            s_d.rx_resp.code = UFS_HS_NAK;
            s_d.rx_void = 1'b1;
         end else begin
            unique case (rx_evt.outcome)
               UFS_RX_OK: begin
                  s_d.rx_resp.code = UFS_HS_ACK;
                  s_d.end_ow = 1'b1;
                  s_d.rx_valid[s_q.rx_wsel] = 1'b1;
                  s_d.rx_wsel = !s_q.rx_wsel;
                  {s_d.rx_ack, s_d.rx_err, s_d.rx_void, s_d.rx_setup} = 4'h8;
                  s_d.rx_irq = 1'b1;
               end
               UFS_RX_TIMEOUT: begin
                  if (!s_q.ctrl[UFS_CTRL_RX_SPM]) s_d.rx_void = 1'b1;
               end
               UFS_RX_TOGGLE: begin
                  s_d.rx_resp.code = UFS_HS_ACK;
                  s_d.end_ow = 1'b1;
               end
               default: begin
                  // CRC error or buffer overflow: write pointer stays where it was
                  {s_d.rx_ack, s_d.rx_err, s_d.rx_void, s_d.rx_setup} = 4'h4;
                  s_d.rx_ovf = s_q.rx_ovf || (rx_evt.outcome == UFS_RX_OVFL);
                  s_d.rx_irq = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tx_resp = s_q.tx_resp;
   assign rx_resp = s_q.rx_resp;
   assign tx_byte_count = s_q.tx_cnt;
   assign rx_irq = s_q.rx_irq;
   assign sof_irq = s_q.sof_irq;

   // Checks
   property p_sof_flush;
      @(posedge clock) disable iff (!arst_n)
      (sof && !tx_evt.in_done && !req.wr && tx_left == UFS_CNT_TWO)
         |=> (sof_irq && s_q.tx_flush && s_q.tx_valid != UFS_CNT_TWO);
   endproperty
   a_sof_flush: assert property (p_sof_flush) else $error("frame flush missing");

   property p_cnt_full;
      @(posedge clock) disable iff (!arst_n)
      (req.wr && req.addr == UFS_REG_TX_CNT && s_q.tx_valid == UFS_CNT_TWO && !sof)
         |=> (s_q.tx_ovf && s_q.tx_valid == UFS_CNT_TWO);
   endproperty
   a_cnt_full: assert property (p_cnt_full) else $error("overrun not set on full");

   property p_iso_void;
      @(posedge clock) disable iff (!arst_n)
      (tx_evt.in_done && s_q.ctrl[UFS_CTRL_TX_EP_EN] && !s_q.ctrl[UFS_CTRL_TX_OE])
         |=> (tx_resp.valid && tx_resp.code == UFS_HS_NONE && s_q.tx_void);
   endproperty
   a_iso_void: assert property (p_iso_void) else $error("iso void answer wrong");

   property p_underrun;
      @(posedge clock) disable iff (!arst_n)
      (tx_evt.in_done && tx_evt.underrun
         && s_q.ctrl[UFS_CTRL_TX_EP_EN] && s_q.ctrl[UFS_CTRL_TX_OE]
         && !s_q.tx_ovf && !s_q.tx_urf && tx_avail != UFS_CNT_EMPTY && !sof)
         |=> (tx_resp.code == UFS_HS_BADSTUFF && s_q.tx_err && !s_q.tx_ack && s_q.tx_urf_pend);
   endproperty
   a_underrun: assert property (p_underrun) else $error("underrun handling wrong");

   property p_sticky;
      @(posedge clock) disable iff (!arst_n)
      (s_q.rx_ovf && !(req.wr && req.addr == UFS_REG_RX_STAT) && !rx_evt.valid)
         |=> s_q.rx_ovf;
   endproperty
   a_sticky: assert property (p_sticky) else $error("overrun cleared by itself");

   property p_out_nak;
      @(posedge clock) disable iff (!arst_n)
      (rx_evt.valid && !rx_evt.setup && s_q.ctrl[UFS_CTRL_RX_EP_EN] && !rx_out_ok)
         |=> (rx_resp.code == UFS_HS_NAK && s_q.rx_void && !rx_irq);
   endproperty
   a_out_nak: assert property (p_out_nak) else $error("OUT not refused");

   property p_out_ok;
      @(posedge clock) disable iff (!arst_n)
      (rx_evt.valid && !rx_evt.setup && s_q.ctrl[UFS_CTRL_RX_EP_EN] && rx_out_ok
         && rx_evt.outcome == UFS_RX_OK && s_q.rx_valid == UFS_CNT_EMPTY && !req.wr)
         |=> (rx_resp.code == UFS_HS_ACK && rx_irq && s_q.rx_ack && s_q.rx_valid == 2'h1);
   endproperty
   a_out_ok: assert property (p_out_ok) else $error("good OUT not taken");

   property p_setup_ok;
      @(posedge clock) disable iff (!arst_n)
      (rx_evt.valid && rx_evt.setup && s_q.ctrl[UFS_CTRL_RX_EP_EN]
         && rx_evt.outcome == UFS_RX_OK && !req.wr)
         |=> (rx_resp.code == UFS_HS_ACK && s_q.rx_valid == 2'h1 && s_q.rx_setup
         && !s_q.rx_ovf && rx_irq);
   endproperty
   a_setup_ok: assert property (p_setup_ok) else $error("good SETUP not taken");

   property p_empty_read;
      @(posedge clock) disable iff (!arst_n)
      (req.rd && req.addr == UFS_REG_RX_DATA && s_q.rx_valid == UFS_CNT_EMPTY
         && !rx_evt.valid) |=> (s_q.rx_urf && !rx_irq);
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty read not flagged");

   c_flush: cover property (@(posedge clock) disable iff (!arst_n) sof_irq);
   c_setup: cover property (@(posedge clock) disable iff (!arst_n)
      rx_resp.valid && rx_resp.code == UFS_HS_ACK && s_q.rx_setup);
   c_badstuff: cover property (@(posedge clock) disable iff (!arst_n)
      tx_resp.code == UFS_HS_BADSTUFF);

endmodule : ufs_endpoint

// ---- core/ufs_pkg.sv ----
package ufs_pkg;

   // Register byte offsets on the AHB-Lite bus
   localparam logic [7:0] UFS_REG_CTRL = 8'h00;
   localparam logic [7:0] UFS_REG_TX_CNT = 8'h04;
   localparam logic [7:0] UFS_REG_TX_STAT = 8'h08;
   localparam logic [7:0] UFS_REG_RX_STAT = 8'h0C;
   localparam logic [7:0] UFS_REG_RX_CMD = 8'h10;
   localparam logic [7:0] UFS_REG_RX_DATA = 8'h14;

   // Control register fields
   localparam int UFS_CTRL_W = 7;
   localparam int UFS_CTRL_TX_EP_EN = 0;
   localparam int UFS_CTRL_TX_OE = 1;
   localparam int UFS_CTRL_TX_ATM = 2;
   localparam int UFS_CTRL_RX_EP_EN = 3;
   localparam int UFS_CTRL_RX_IE = 4;
   localparam int UFS_CTRL_RX_STALL = 5;
   localparam int UFS_CTRL_RX_SPM = 6;
   localparam logic [6:0] UFS_CTRL_RESET = 7'h00;

   // Transmit status fields (count sits in bits 1:0)
   localparam int UFS_TXS_ERR = 2;
   localparam int UFS_TXS_ACK = 3;
   localparam int UFS_TXS_VOID = 4;
   localparam int UFS_TXS_OVF = 5;
   localparam int UFS_TXS_URF = 6;
   localparam int UFS_TXS_FLUSH = 7;

   // Receive status fields (count sits in bits 1:0)
   localparam int UFS_RXS_ERR = 2;
   localparam int UFS_RXS_ACK = 3;
   localparam int UFS_RXS_VOID = 4;
   localparam int UFS_RXS_SETUP = 5;
   localparam int UFS_RXS_OVF = 6;
   localparam int UFS_RXS_URF = 7;
   localparam int UFS_RXS_SETUP_OVERWRITE_FLAG = 8;
   localparam int UFS_RXS_END_DATA_OVERWRITE_FLAG = 9;
   localparam int UFS_RXC_DONE = 0;

   localparam int UFS_TX_CNT_W = 8;
   localparam logic [1:0] UFS_CNT_EMPTY = 2'h0;
   localparam logic [1:0] UFS_CNT_TWO = 2'h3;

   // Handshake chosen for a transaction
   typedef enum logic [4:0] {
      UFS_HS_NONE = 5'h01,
      UFS_HS_ACK = 5'h02,
      UFS_HS_NAK = 5'h04,
      UFS_HS_DATA = 5'h08,
      UFS_HS_BADSTUFF = 5'h10
   } ufs_hs_type;

   // Outcome of a receive data phase as seen by the serial engine
   typedef enum logic [4:0] {
      UFS_RX_OK = 5'h01,
      UFS_RX_TIMEOUT = 5'h02,
      UFS_RX_CRC = 5'h04,
      UFS_RX_OVFL = 5'h08,
      UFS_RX_TOGGLE = 5'h10
   } ufs_rx_out_type;

   typedef struct packed {
      logic in_done;
      logic underrun;
   } ufs_tx_evt_type;

   typedef struct packed {
      logic valid;
      logic setup;
      ufs_rx_out_type outcome;
   } ufs_rx_evt_type;

   typedef struct packed {
      logic valid;
      ufs_hs_type code;
   } ufs_resp_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
   } ufs_bus_req_type;

endpackage : ufs_pkg

// ---- verif/ufs_endpoint_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module ufs_endpoint_tb
   import ufs_pkg::*;
;
   typedef struct packed {
      logic [6:0] ctrl;
      logic setup;
      ufs_rx_out_type oc;
      ufs_hs_type code;
      logic irq;
      logic [7:0] stat;
   } ufs_row_type;

   logic clock, arst_n, hsel, hwrite, hreadyout, hresp, sof, rx_setup_token, rx_irq, sof_irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] tx_byte_count;
   ufs_tx_evt_type tx_evt;
   ufs_rx_evt_type rx_evt;
   ufs_resp_type tx_resp, rx_resp;
   int fail_count, n_checks, cycles;

   // Single transactions from an empty endpoint; control traffic kept single-packet
   ufs_row_type rows [11] = '{
      '{7'h48, 1'b0, UFS_RX_OK, UFS_HS_NAK, 1'b0, 8'h10},
      '{7'h58, 1'b0, UFS_RX_OK, UFS_HS_ACK, 1'b1, 8'h09},
      '{7'h58, 1'b0, UFS_RX_TIMEOUT, UFS_HS_NONE, 1'b0, 8'h00},
      '{7'h18, 1'b0, UFS_RX_TIMEOUT, UFS_HS_NONE, 1'b0, 8'h10},
      '{7'h58, 1'b0, UFS_RX_CRC, UFS_HS_NONE, 1'b1, 8'h04},
      '{7'h58, 1'b0, UFS_RX_OVFL, UFS_HS_NONE, 1'b1, 8'h44},
      '{7'h58, 1'b0, UFS_RX_TOGGLE, UFS_HS_ACK, 1'b0, 8'h00},
      '{7'h68, 1'b1, UFS_RX_OK, UFS_HS_ACK, 1'b1, 8'h29},
      '{7'h58, 1'b1, UFS_RX_TIMEOUT, UFS_HS_NONE, 1'b1, 8'h04},
      '{7'h58, 1'b1, UFS_RX_CRC, UFS_HS_NONE, 1'b1, 8'h24},
      '{7'h58, 1'b1, UFS_RX_OVFL, UFS_HS_NONE, 1'b1, 8'h64}
   };

   ufs_endpoint dut_u (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sof(sof), .tx_evt(tx_evt),
      .rx_setup_token(rx_setup_token), .rx_evt(rx_evt), .tx_resp(tx_resp),
      .rx_resp(rx_resp), .tx_byte_count(tx_byte_count), .rx_irq(rx_irq), .sof_irq(sof_irq));

   ufs_host_model host_u (.clock(clock), .sof(sof), .tx_evt(tx_evt),
      .rx_setup_token(rx_setup_token), .rx_evt(rx_evt));

   // 50 MHz clock
   always #10 clock = ~clock;

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         summarize();
      end
   end

   // One AHB-Lite single word; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic stchk(input logic [7:0] a, input logic [7:0] e);
      ahb(1'b0, a, 32'h00000000);
      `CHK(rd[7:0], e)
   endtask : stchk

   // Receive transaction and the handshake seen one cycle later
   task automatic rxchk(input logic s, input ufs_rx_out_type oc, input ufs_hs_type c,
                        input logic irq);
      host_u.end_rx(s, oc);
      #1;
      `CHK(rx_resp, {1'b1, c})
      `CHK(rx_irq, irq)
   endtask : rxchk

   // Short reset between cases so every row starts from the empty state
   task automatic rst();
      @(posedge clock);
      arst_n <= 1'b0;
      @(posedge clock);
      arst_n <= 1'b1;
   endtask : rst

   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         rst();
         ahb(1'b1, UFS_REG_CTRL, {25'h0000000, rows[i].ctrl});
         if (rows[i].setup) host_u.token();
         rxchk(rows[i].setup, rows[i].oc, rows[i].code, rows[i].irq);
         stchk(UFS_REG_RX_STAT, rows[i].stat);
      end
      // Held packet, release, overflow lock-out, then SETUP recovery
      rst();
      ahb(1'b1, UFS_REG_CTRL, 32'h00000058);
      rxchk(1'b0, UFS_RX_OK, UFS_HS_ACK, 1'b1);
      rxchk(1'b0, UFS_RX_OK, UFS_HS_NAK, 1'b0);
      stchk(UFS_REG_RX_STAT, 8'h19);
      ahb(1'b1, UFS_REG_RX_CMD, 32'h00000001);
      stchk(UFS_REG_RX_STAT, 8'h18);
      rxchk(1'b0, UFS_RX_OVFL, UFS_HS_NONE, 1'b1);
      rxchk(1'b0, UFS_RX_OK, UFS_HS_NAK, 1'b0);
      stchk(UFS_REG_RX_STAT, 8'h54);
      host_u.token();
      stchk(UFS_REG_RX_STAT, 8'h54);
      `CHK(rd[8], 1'b1)
      rxchk(1'b1, UFS_RX_OK, UFS_HS_ACK, 1'b1);
      stchk(UFS_REG_RX_STAT, 8'h29);
      `CHK(rd[9:8], 2'b10)
      // Empty read locks OUT traffic until firmware clears the flag
      rst();
      ahb(1'b1, UFS_REG_CTRL, 32'h00000058);
      stchk(UFS_REG_RX_DATA, 8'h00);
      stchk(UFS_REG_RX_STAT, 8'h80);
      rxchk(1'b0, UFS_RX_OK, UFS_HS_NAK, 1'b0);
      ahb(1'b1, UFS_REG_RX_STAT, 32'h00000080);
      stchk(UFS_REG_RX_STAT, 8'h10);
      rxchk(1'b0, UFS_RX_OK, UFS_HS_ACK, 1'b1);
      // Isochronous transmit: overrun, stale flush, underrun at frame start
      rst();
      ahb(1'b1, UFS_REG_CTRL, 32'h00000007);
      ahb(1'b1, UFS_REG_TX_CNT, 32'h00000040);
      ahb(1'b1, UFS_REG_TX_CNT, 32'h00000040);
      `CHK(tx_byte_count, 8'h40)
      ahb(1'b1, UFS_REG_TX_CNT, 32'h00000041);
      stchk(UFS_REG_TX_STAT, 8'h23);
      host_u.frame();
      #1;
      `CHK(sof_irq, 1'b1)
      stchk(UFS_REG_TX_STAT, 8'hA2);
      `CHK(rd[7:2], 6'b101000)
      `CHK(rd[1] ^ rd[0], 1'b1)
      ahb(1'b1, UFS_REG_TX_STAT, 32'h000000A0);
      host_u.end_in(1'b1);
      #1;
      `CHK(tx_resp, {1'b1, UFS_HS_BADSTUFF})
      stchk(UFS_REG_TX_STAT, 8'h06);
      `CHK(rd[7:2], 6'b000001)
      `CHK(rd[1] ^ rd[0], 1'b1)
      host_u.frame();
      #1;
      `CHK(sof_irq, 1'b0)
      stchk(UFS_REG_TX_STAT, 8'h44);
      ahb(1'b1, UFS_REG_TX_CNT, 32'h00000040);
      host_u.end_in(1'b0);
      #1;
      `CHK(tx_resp, {1'b1, UFS_HS_NONE})
      stchk(UFS_REG_TX_STAT, 8'h55);
      `CHK(rd[7:2], 6'b010101)
      ahb(1'b1, UFS_REG_TX_STAT, 32'h00000040);
      ahb(1'b1, UFS_REG_CTRL, 32'h00000005);
      host_u.end_in(1'b0);
      #1;
      `CHK(tx_resp, {1'b1, UFS_HS_NONE})
      ahb(1'b1, UFS_REG_CTRL, 32'h00000007);
      host_u.end_in(1'b0);
      #1;
      `CHK(tx_resp, {1'b1, UFS_HS_DATA})
      stchk(UFS_REG_TX_STAT, 8'h09);
      `CHK(rd[4:2], 3'b010)
      // Mid-run reset empties both buffers and drops every flag
      rst();
      stchk(UFS_REG_TX_STAT, 8'h00);
      stchk(UFS_REG_RX_STAT, 8'h00);
      summarize();
   end
endmodule : ufs_endpoint_tb

// ---- verif/ufs_host_model.sv ----
`timescale 1ns/1ps
module ufs_host_model
   import ufs_pkg::*;
(
   input wire logic clock,
   output logic sof,
   output ufs_tx_evt_type tx_evt,
   output logic rx_setup_token,
   output ufs_rx_evt_type rx_evt
);
   // Quiet link at start; every event below is a single-cycle pulse
   initial begin
      sof = 1'b0;
      tx_evt = '0;
      rx_setup_token = 1'b0;
      rx_evt = '{1'b0, 1'b0, UFS_RX_OK};
   end

   // Close an OUT or SETUP data phase; outcome only means something with valid
   task automatic end_rx(input logic setup, input ufs_rx_out_type oc);
      @(posedge clock);
      rx_evt <= '{1'b1, setup, oc};
      @(posedge clock);
      rx_evt <= '{1'b0, 1'b0, UFS_RX_TIMEOUT};
   endtask : end_rx

   // Token decode comes at least two cycles ahead of the data phase, as on the wire
   task automatic token();
      @(posedge clock);
      rx_setup_token <= 1'b1;
      @(posedge clock);
      rx_setup_token <= 1'b0;
   endtask : token

   // Close an isochronous IN, optionally starving the FIFO mid-packet
   task automatic end_in(input logic starve);
      @(posedge clock);
      tx_evt <= '{1'b1, starve};
      @(posedge clock);
      tx_evt <= '0;
   endtask : end_in

   // Frame start marker
   task automatic frame();
      @(posedge clock);
      sof <= 1'b1;
      @(posedge clock);
      sof <= 1'b0;
   endtask : frame
endmodule : ufs_host_model
